// >>> bench/uec_cfg_txirq_checker.sv
// ==========================================
// Port checker
module uec_cfg_txirq_checker
  import uec_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [2:0] cpuAddr,
  input wire logic [7:0] cpuDataIn,
  input wire logic [7:0] cpuDataOut,
  input wire logic       cpuDataOe,
  input wire logic       cpuRd,
  input wire logic       cpuWr,
  input wire logic       rtsOut,
  input wire logic       irMode,
  input wire logic       prescTick,
  input wire logic       interruptOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] line_control;
  logic [7:0] lcNxt;
  logic       gateR;
  logic       gateNxt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Shadow of bank select and gate, so decode is judged from the bus alone
  always_comb begin
    lcNxt = line_control;
    gateNxt = gateR;
    if (cpuWr && cpuAddr == OFS_LINE_CTL) lcNxt = cpuDataIn;
    if (cpuWr && cpuAddr == OFS_FIFO_CTL && line_control == BANK_KEY) gateNxt = cpuDataIn[FE_GATE];
  end
  always_ff @(posedge clk) begin
    line_control <= sys_rst ? REG_RST : lcNxt;
    gateR <= sys_rst ? 1'b0 : gateNxt;
  end
  sequence s_mc_wr; cpuWr && cpuAddr == OFS_MODEM_CTL && line_control != BANK_KEY; endsequence
  sequence s_hold_wr; cpuWr && cpuAddr == OFS_HOLD && !line_control[LC_DLAB]; endsequence
  sequence s_id_rd; cpuRd && cpuAddr == OFS_FIFO_CTL && line_control != BANK_KEY; endsequence
  property p_rts;
    s_mc_wr |-> ##2 rtsOut == $past(cpuDataIn[MC_RTS], 2);
  endproperty
  property p_ir;
    s_mc_wr ##0 gateR |=> irMode == $past(cpuDataIn[MC_IR]);
  endproperty
  a_oe_after_rd: assert property (cpuRd |=> cpuDataOe) else $error("read strobe missing");
  a_oe_quiet: assert property (!cpuRd |=> !cpuDataOe) else $error("stray read strobe");
  a_irq_holds: assert property (interruptOut && !cpuRd && !cpuWr |=> interruptOut)
    else $error("interrupt dropped without access");
  a_irq_wr_clear: assert property (interruptOut ##0 s_hold_wr |=> !interruptOut)
    else $error("holding write left interrupt");
  a_irq_id_clear: assert property (interruptOut ##0 s_id_rd |=> !interruptOut || cpuDataOut[5:1] != CODE_THRE)
    else $error("identification read left interrupt");
  a_rts_follow: assert property (p_rts) else $error("rts not following modem bit");
  a_ir_follow: assert property (p_ir) else $error("infrared mode not following");
  a_div1_steady: assert property (s_mc_wr ##0 gateR && !cpuDataIn[MC_PRESC] |=> ##2 prescTick [*4])
    else $error("undivided tick gap");
  a_div4_sparse: assert property (
    s_mc_wr ##0 gateR && cpuDataIn[MC_PRESC] |=> ##4 !(prescTick && $past(prescTick)))
    else $error("divided tick too dense");
endmodule : uec_cfg_txirq_checker

bind uec_cfg_txirq uec_cfg_txirq_checker i_chk (.clk(clk), .sys_rst(sys_rst), .cpuAddr(cpuAddr),
  .cpuDataIn(cpuDataIn), .cpuDataOut(cpuDataOut), .cpuDataOe(cpuDataOe), .cpuRd(cpuRd), .cpuWr(cpuWr),
  .rtsOut(rtsOut), .irMode(irMode), .prescTick(prescTick), .interruptOut(interruptOut));

// >>> bench/uec_cfg_txirq_tb_top.sv
`define CHK(a,e) begin cmpCount++; if ((a) !== (e)) begin badCount++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
// ==========================================
// Testbench top
module uec_cfg_txirq_tb_top;
  import uec_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] lc; logic [2:0] ofs; logic [7:0] wd; logic [7:0] rx;} uec_row_t;
  uec_row_t rows [7] = '{'{8'hbf, 3'h4, 8'h11, 8'h11}, '{8'hbf, 3'h6, 8'h13, 8'h13},
    '{8'hbf, 3'h5, 8'h12, 8'h12}, '{8'hbf, 3'h7, 8'h14, 8'h14}, '{8'hbf, 3'h2, 8'h1a, 8'h1a},
    '{8'h00, 3'h4, 8'h03, 8'h03}, '{8'h00, 3'h7, 8'h5a, 8'h00}};
  logic [6:0] lvls [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
  int         badCount = 0;
  int         cmpCount = 0;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       txTake = 1'b0;
  logic       ctsIn = 1'b1;
  logic [2:0] cpuAddr;
  logic [7:0] cpuDataIn, cpuDataOut, rdv, resumeChar1, resumeChar2, pauseChar1, pauseChar2, n, txData;
  logic [1:0] rxThreshold;
  logic       cpuDataOe, cpuRd, cpuWr, txValid, rtsOut, autoRtsEn, irMode, prescTick, txDmaReq, interruptOut;
  logic [3:0] softFlowMode;

  always #12.5 clk = ~clk;

  uec_host_model i_host (.clk(clk), .cpuAddr(cpuAddr), .cpuDataIn(cpuDataIn), .cpuRd(cpuRd), .cpuWr(cpuWr),
    .cpuDataOut(cpuDataOut));
  uec_cfg_txirq #(.FIFO_DEPTH(DEPTH_LARGE)) i_dut (.clk(clk), .sys_rst(sys_rst), .cpuAddr(cpuAddr),
    .cpuDataIn(cpuDataIn), .cpuDataOut(cpuDataOut), .cpuDataOe(cpuDataOe), .cpuRd(cpuRd), .cpuWr(cpuWr),
    .txData(txData), .txValid(txValid), .txTake(txTake), .ctsIn(ctsIn), .rtsOut(rtsOut), .autoRtsEn(autoRtsEn),
    .softFlowMode(softFlowMode), .resumeChar1(resumeChar1), .resumeChar2(resumeChar2),
    .pauseChar1(pauseChar1), .pauseChar2(pauseChar2), .rxThreshold(rxThreshold), .irMode(irMode),
    .prescTick(prescTick), .txDmaReq(txDmaReq), .interruptOut(interruptOut));

  task automatic wrapUp();
    $display("Comparisons %0d, mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrapUp

  // Transmitter pulls cnt characters, each after waiting up to eight cycles for one to be offered
  task automatic take(input int cnt);
    repeat (cnt) begin
      @(negedge clk);
      for (int w = 0; w < 8 && txValid !== 1'b1; w++) @(negedge clk);
      txTake = 1'b1;
      @(negedge clk);
      txTake = 1'b0;
    end
    repeat (3) @(negedge clk);
  endtask : take

  initial begin
    #500000;
    badCount++;
    wrapUp();
  end

  initial begin
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    `CHK({cpuDataOe, interruptOut, txValid}, 3'b000)
    foreach (rows[i]) begin
      i_host.wr(OFS_LINE_CTL, rows[i].lc);
      i_host.wr(rows[i].ofs, rows[i].wd);
      i_host.rd(rows[i].ofs, rdv);
      `CHK(rdv, rows[i].rx)
    end
    `CHK({resumeChar1, resumeChar2, pauseChar1, pauseChar2}, 32'h11121314)
    `CHK(softFlowMode, 4'ha)
    for (int k = 0; k < 2; k++) begin
      n = 8'h00;
      i_host.wr(OFS_MODEM_CTL, k ? 8'h00 : 8'h80);
      repeat (4) @(negedge clk);
      repeat (40) begin
        @(negedge clk);
        n += {7'h00, prescTick};
      end
      `CHK(n, k ? 8'h28 : 8'h0a)
    end
    i_host.wr(OFS_IRQ_EN, 8'h02);
    for (int k = 0; k < 4; k++) begin
      i_host.gated(OFS_FIFO_CTL, {2'h0, k[1:0], 4'hd});
      repeat (3) @(negedge clk);
      `CHK({txDmaReq, interruptOut}, 2'b11)
      // One more than the depth, since the output stage holds a character too
      for (int c = 0; c < 65; c++) i_host.wr(OFS_HOLD, c[7:0]);
      repeat (3) @(negedge clk);
      `CHK({txDmaReq, interruptOut}, 2'b00)
      take(lvls[k] - 7'h01);
      `CHK(interruptOut, 1'b0)
      take(1);
      `CHK({txDmaReq, interruptOut}, 2'b01)
      take(1);
      `CHK(txDmaReq, 1'b1)
    end
    i_host.rd(OFS_FIFO_CTL, rdv);
    `CHK(rdv, 8'hc2)
    `CHK(interruptOut, 1'b0)
    take(8);
    `CHK(interruptOut, 1'b0)
    i_host.wr(OFS_HOLD, 8'h5a);
    repeat (4) @(negedge clk);
    `CHK(interruptOut, 1'b1)
    `CHK({txValid, txData}, 9'h15a)
    i_host.wr(OFS_LINE_CTL, BANK_KEY);
    i_host.wr(OFS_FIFO_CTL, 8'hda);
    i_host.wr(OFS_LINE_CTL, REG_RST);
    // A deasserted clear-to-send pin must hold the next character back
    ctsIn = 1'b0;
    repeat (4) @(negedge clk);
    i_host.wr(OFS_HOLD, 8'h77);
    take(1);
    `CHK(txValid, 1'b0)
    ctsIn = 1'b1;
    repeat (8) @(negedge clk);
    `CHK({txValid, txData}, 9'h177)
    i_host.gated(OFS_IRQ_EN, 8'hc2);
    i_host.gated(OFS_MODEM_CTL, 8'h42);
    i_host.gated(OFS_FIFO_CTL, 8'hc1);
    repeat (3) @(negedge clk);
    `CHK({autoRtsEn, rtsOut, irMode}, 3'b111)
    `CHK(rxThreshold, 2'h3)
    wrapUp();
  end
endmodule : uec_cfg_txirq_tb_top

// >>> bench/uec_host_model.sv
// ==========================================
// Host processor on the register port
module uec_host_model
  import uec_pkg::*;
(
  input  wire logic       clk,
  output logic      [2:0] cpuAddr,
  output logic      [7:0] cpuDataIn,
  output logic            cpuRd,
  output logic            cpuWr,
  input  wire logic [7:0] cpuDataOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lcShadow = REG_RST;
  logic [7:0] feShadow = REG_RST;
  initial begin
    cpuAddr = 3'h0;
    cpuDataIn = 8'h00;
    cpuRd = 1'b0;
    cpuWr = 1'b0;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    cpuAddr = a;
    cpuDataIn = d;
    cpuWr = 1'b1;
    @(negedge clk);
    cpuWr = 1'b0;
    cpuDataIn = ~d;
    if (a == OFS_LINE_CTL) lcShadow = d;
    if (a == OFS_FIFO_CTL && lcShadow == BANK_KEY) feShadow = d;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    cpuAddr = a;
    cpuRd = 1'b1;
    @(negedge clk);
    cpuRd = 1'b0;
    d = cpuDataOut;
  endtask : rd
  // Gated write; the caller's bank select survives the sequence
  task automatic gated(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] saved;
    saved = lcShadow;
    wr(OFS_LINE_CTL, BANK_KEY);
    wr(OFS_FIFO_CTL, feShadow | 8'h10);
    wr(OFS_LINE_CTL, REG_RST);
    wr(a, d);
    wr(OFS_LINE_CTL, saved);
  endtask : gated
endmodule : uec_host_model

// >>> rtl/uec_cfg_txirq.sv
module uec_cfg_txirq
  import uec_pkg::*;
#(
  parameter int FIFO_DEPTH = DEPTH_LARGE
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] cpuAddr,
  input  wire logic [7:0] cpuDataIn,
  output logic      [7:0] cpuDataOut,
  output logic            cpuDataOe,
  input  wire logic       cpuRd,
  input  wire logic       cpuWr,
  output logic      [7:0] txData,
  output logic            txValid,
  input  wire logic       txTake,
  input  wire logic       ctsIn,
  output logic            rtsOut,
  output logic            autoRtsEn,
  output logic      [3:0] softFlowMode,
  output logic      [7:0] resumeChar1,
  output logic      [7:0] resumeChar2,
  output logic      [7:0] pauseChar1,
  output logic      [7:0] pauseChar2,
  output logic      [1:0] rxThreshold,
  output logic            irMode,
  output logic            prescTick,
  output logic            txDmaReq,
  output logic            interruptOut
);

  localparam int  CW    = $clog2(FIFO_DEPTH) + 1;
  localparam bit  LARGE = (FIFO_DEPTH == DEPTH_LARGE);

  if (FIFO_DEPTH != DEPTH_SMALL && FIFO_DEPTH != DEPTH_LARGE) begin : g_bad_depth
    $error("uec_cfg_txirq supports FIFO depths 16 and 64 only");
  end

  // ==========================================================
  // Configuration registers
  logic [7:0] lineCtl_r,  lineCtl_nxt;
  logic [7:0] irqEn_r,    irqEn_nxt;
  logic [7:0] feature_r,  feature_nxt;
  logic [7:0] fifoCtl_r,  fifoCtl_nxt;
  logic [7:0] modemCtl_r, modemCtl_nxt;
  logic [7:0] resume1_r,  resume1_nxt;
  logic [7:0] resume2_r,  resume2_nxt;
  logic [7:0] pause1_r,   pause1_nxt;
  logic [7:0] pause2_r,   pause2_nxt;

  logic bankSel;
  logic gateOpen;
  logic dlab;
  logic holdWr;
  logic txFlush;

  assign bankSel  = (lineCtl_r == BANK_KEY);
  assign gateOpen = feature_r[FE_GATE];
  assign dlab     = lineCtl_r[LC_DLAB] && !bankSel;
  assign holdWr   = cpuWr && cpuAddr == OFS_HOLD && !dlab;
  assign txFlush  = cpuWr && cpuAddr == OFS_FIFO_CTL && !bankSel && cpuDataIn[FC_TX_RST];

  always_comb begin
    lineCtl_nxt  = lineCtl_r;
    irqEn_nxt    = irqEn_r;
    feature_nxt  = feature_r;
    fifoCtl_nxt  = fifoCtl_r;
    modemCtl_nxt = modemCtl_r;
    resume1_nxt  = resume1_r;
    resume2_nxt  = resume2_r;
    pause1_nxt   = pause1_r;
    pause2_nxt   = pause2_r;
    if (cpuWr) begin
      case (cpuAddr)
        OFS_IRQ_EN: if (!dlab) irqEn_nxt = gated_merge(irqEn_r, cpuDataIn, IE_GATED, gateOpen);  // [R09]
        OFS_FIFO_CTL: begin
          if (bankSel) begin
            feature_nxt = cpuDataIn;                                                    // [R04] [R09]
          end else begin
            // Reset bits are actions, never stored
            fifoCtl_nxt = gated_merge(fifoCtl_r, cpuDataIn, FC_GATED, gateOpen) & ~FC_PULSES; // [R08] [R10] [R21]
          end
        end
        OFS_LINE_CTL: lineCtl_nxt = cpuDataIn;
        OFS_MODEM_CTL: begin
          if (bankSel) resume1_nxt = cpuDataIn;                                         // [R02]
          else modemCtl_nxt = gated_merge(modemCtl_r, cpuDataIn, MC_GATED, gateOpen);  // [R21]
        end
        OFS_RESUME2:   if (bankSel) resume2_nxt = cpuDataIn;                                    // [R03]
        OFS_PAUSE1:    if (bankSel) pause1_nxt = cpuDataIn;                                     // [R02]
        OFS_PAUSE2:    if (bankSel) pause2_nxt = cpuDataIn;                                     // [R03]
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lineCtl_r  <= REG_RST;
      irqEn_r    <= REG_RST;
      feature_r  <= REG_RST;
      fifoCtl_r  <= REG_RST;
      modemCtl_r <= REG_RST;
      resume1_r  <= REG_RST;
      resume2_r  <= REG_RST;
      pause1_r   <= REG_RST;
      pause2_r   <= REG_RST;
    end else begin
      lineCtl_r  <= lineCtl_nxt;
      irqEn_r    <= irqEn_nxt;
      feature_r  <= feature_nxt;
      fifoCtl_r  <= fifoCtl_nxt;
      modemCtl_r <= modemCtl_nxt;
      resume1_r  <= resume1_nxt;
      resume2_r  <= resume2_nxt;
      pause1_r   <= pause1_nxt;
      pause2_r   <= pause2_nxt;
    end
  end

  // ==========================================================
  // Clear-to-send pin synchroniser
  logic ctsS1_r, ctsS2_r, ctsS3_r, ctsLvl_r, ctsLvl_nxt;

  // A change counts only once the second and third stages agree
  assign ctsLvl_nxt = (ctsS2_r == ctsS3_r) ? ctsS3_r : ctsLvl_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctsS1_r  <= 1'b0;
      ctsS2_r  <= 1'b0;
      ctsS3_r  <= 1'b0;
      ctsLvl_r <= 1'b0;
    end else begin
      ctsS1_r  <= ctsIn;
      ctsS2_r  <= ctsS1_r;
      ctsS3_r  <= ctsS2_r;
      ctsLvl_r <= ctsLvl_nxt;
    end
  end

  // ==========================================================
  // Transmit FIFO and output stage
  logic [CW-1:0] count;
  logic [7:0]    headData;
  logic [CW-1:0] capacity;
  logic [CW-1:0] spaces;
  logic [CW-1:0] level;
  logic          full;
  logic          empty;
  logic          push;
  logic          pop;
  logic          ctsOk;
  logic [7:0]    outData_r, outData_nxt;
  logic          outValid_r, outValid_nxt;

  // Without FIFO mode the channel holds a single character
  assign capacity = fifoCtl_r[FC_ENABLE] ? CW'(FIFO_DEPTH) : CW'(1);             // [R10] [R11]
  assign full     = (count >= capacity);
  assign empty    = (count == '0);
  assign spaces   = full ? '0 : capacity - count;
  // Small variant offers only the empty level
  assign level    = (LARGE && fifoCtl_r[FC_ENABLE]) ?
                    CW'(tx_space_level(fifoCtl_r[FC_TXLVL_LO +: 2])) : capacity;  // [R13]
  assign ctsOk    = !feature_r[FE_AUTO_CTS] || ctsLvl_r;                          // [R09]
  assign push     = holdWr && !full;
  assign pop      = !empty && ctsOk && (!outValid_r || txTake) && !txFlush;

  uec_tx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk), .sys_rst(sys_rst), .flush(txFlush), .push(push), .pushData(cpuDataIn),
    .pop(pop), .headData(headData), .count(count)
  );

  always_comb begin
    outData_nxt  = outData_r;
    outValid_nxt = outValid_r;
    if (txTake) outValid_nxt = 1'b0;
    if (pop) begin
      outData_nxt  = headData;
      outValid_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      outData_r  <= 8'h00;
      outValid_r <= 1'b0;
    end else begin
      outData_r  <= outData_nxt;
      outValid_r <= outValid_nxt;
    end
  end

  // ==========================================================
  // Transmit-empty interrupt, flow interrupt, DMA request
  logic       threPend_r, threPend_nxt;
  logic [1:0] wrCnt_r,    wrCnt_nxt;
  logic       served_r,   served_nxt;
  logic       flowPend_r, flowPend_nxt;
  logic       dmaReq_r,   dmaReq_nxt;
  logic       interrupt_output_r,     interrupt_output_nxt;
  logic       rts_r,      rts_nxt;
  logic       ctsSeen_r;
  logic       iirRead;
  logic [4:0] code;
  logic       raise;
  logic       flowEvt;

  assign iirRead = cpuRd && cpuAddr == OFS_FIFO_CTL && !bankSel;
  assign rts_nxt = modemCtl_r[MC_RTS];                                            // [R09]
  assign code    = (threPend_r && irqEn_r[IE_THRE]) ? CODE_THRE :
                   flowPend_r ? CODE_FLOW : CODE_NONE;                            // [R12]
  assign flowEvt = (irqEn_r[IE_CTS] && feature_r[FE_AUTO_CTS] && ctsSeen_r != ctsLvl_r) ||
                   (irqEn_r[IE_RTS] && rts_nxt != rts_r);                         // [R09]
  // Threshold path re-arms only after two loads; the drain path after any load
  assign raise   = txFlush ||                                                     // [R20]
                   (wrCnt_r >= HYST_CHARS && spaces >= level) ||                  // [R15]
                   (served_r && empty);                                           // [R19]

  always_comb begin
    wrCnt_nxt  = wrCnt_r;
    served_nxt = served_r;
    if (raise) begin
      wrCnt_nxt  = push ? 2'h1 : 2'h0;
      served_nxt = push;
    end else if (push) begin
      if (wrCnt_r < HYST_CHARS) wrCnt_nxt = wrCnt_r + 2'h1;
      served_nxt = 1'b1;
    end
    // A set in the same cycle as a clear wins
    if (raise) threPend_nxt = 1'b1;
    else if (holdWr || (iirRead && code == CODE_THRE)) threPend_nxt = 1'b0;     // [R17] [R18]
    else threPend_nxt = threPend_r;
    flowPend_nxt = flowEvt || (flowPend_r && !(iirRead && code == CODE_FLOW));
    if (!fifoCtl_r[FC_ENABLE] || !fifoCtl_r[FC_DMA_MODE]) dmaReq_nxt = empty;
    else if (full) dmaReq_nxt = 1'b0;                                            // [R16]
    else if (LARGE ? (spaces > level) : empty) dmaReq_nxt = 1'b1;                // [R10] [R16]
    else dmaReq_nxt = dmaReq_r;
    interrupt_output_nxt = (threPend_nxt && irqEn_r[IE_THRE]) || flowPend_nxt;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      threPend_r <= 1'b0;
      wrCnt_r    <= HYST_CHARS;
      served_r   <= 1'b0;
      flowPend_r <= 1'b0;
      dmaReq_r   <= 1'b0;
      interrupt_output_r     <= 1'b0;
      rts_r      <= 1'b0;
      ctsSeen_r  <= 1'b0;
    end else begin
      threPend_r <= threPend_nxt;
      wrCnt_r    <= wrCnt_nxt;
      served_r   <= served_nxt;
      flowPend_r <= flowPend_nxt;
      dmaReq_r   <= dmaReq_nxt;
      interrupt_output_r     <= interrupt_output_nxt;
      rts_r      <= rts_nxt;
      ctsSeen_r  <= ctsLvl_r;
    end
  end

  // ==========================================================
  // Prescaler
  logic [1:0] prescCnt_r, prescCnt_nxt;
  logic       tick_r,     tick_nxt;

  always_comb begin
    prescCnt_nxt = modemCtl_r[MC_PRESC] ? prescCnt_r + 2'h1 : 2'h0;
    tick_nxt     = modemCtl_r[MC_PRESC] ? (prescCnt_r == PRESC_LAST) : 1'b1;      // [R06] [R07]
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prescCnt_r <= 2'h0;
      tick_r     <= 1'b0;
    end else begin
      prescCnt_r <= prescCnt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  // ==========================================================
  // Read data
  logic [7:0] rdData_r, rdData_nxt;
  logic       rdOe_r;

  always_comb begin
    rdData_nxt = 8'h00;
    case (cpuAddr)
      OFS_IRQ_EN:    rdData_nxt = dlab ? 8'h00 : irqEn_r;
      OFS_FIFO_CTL:  rdData_nxt = bankSel ? feature_r :
                                  {{2{fifoCtl_r[FC_ENABLE]}}, code, code == CODE_NONE};  // [R12] [R21]
      OFS_LINE_CTL:  rdData_nxt = lineCtl_r;
      OFS_MODEM_CTL: rdData_nxt = bankSel ? resume1_r : modemCtl_r;                // [R02]
      OFS_LINE_STAT: rdData_nxt = bankSel ? resume2_r :                            // [R03]
                     8'((8'(empty) << LS_FIFO_EMP) | (8'(empty && !outValid_r) << LS_ALL_EMP));
      OFS_PAUSE1:    rdData_nxt = bankSel ? pause1_r : 8'h00;                      // [R02]
      OFS_PAUSE2:    rdData_nxt = bankSel ? pause2_r : 8'h00;                      // [R03]
      default:       rdData_nxt = 8'h00;
    endcase
    if (!cpuRd) rdData_nxt = rdData_r;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdData_r <= 8'h00;
      rdOe_r   <= 1'b0;
    end else begin
      rdData_r <= rdData_nxt;
      rdOe_r   <= cpuRd;
    end
  end

  // ==========================================================
  // Outputs
  assign cpuDataOut   = rdData_r;
  assign cpuDataOe    = rdOe_r;
  assign txData       = outData_r;
  assign txValid      = outValid_r;
  assign rtsOut       = rts_r;
  assign autoRtsEn    = feature_r[FE_AUTO_RTS];
  assign softFlowMode = feature_r[3:0];                                            // [R04]
  assign resumeChar1  = resume1_r;
  assign resumeChar2  = resume2_r;
  assign pauseChar1   = pause1_r;
  assign pauseChar2   = pause2_r;
  assign rxThreshold  = fifoCtl_r[7:6];                                            // [R08]
  assign irMode       = modemCtl_r[MC_IR];                                         // [R14]
  assign prescTick    = tick_r;
  assign txDmaReq     = dmaReq_r;
  assign interruptOut = interrupt_output_r;

endmodule : uec_cfg_txirq

// >>> rtl/uec_pkg.sv
// Functional notes
// R01: Software saves line-control before extended setup and restores it afterwards.
// R02: With line-control 0xBF, offsets 0x04/0x06 reach first resume/pause characters.
// R03: With line-control 0xBF, offsets 0x05/0x07 reach second resume/pause characters.
// R04: Feature-enable bits 3:0 select the automatic software flow-control mode.
// R05: Software sets feature-enable bit 4 before writing gated enhanced fields.
// R06: Modem-control bit 7 set makes the prescaler divide the clock by four.
// R07: Modem-control bit 7 clear makes the prescaler pass the clock undivided.
// R08: Gated fifo-control write programs receive and, on large variant, transmit thresholds.
// R09: Feature bits 7:6 enable auto RTS/CTS; enable bits 7:6 their interrupts; RTS bit.
// R10: Fifo-control bit 0 enables FIFOs, bit 3 selects block DMA using thresholds.
// R11: Transmit FIFO holds 16 or 64 entries depending on variant.
// R12: Interrupt identification reports the source as a five-bit code.
// R13: Fifo-control bits 5:4 pick four transmit levels on large variant, one otherwise.
// R14: Modem-control bit 6 enables infrared encode and decode.
// R15: Threshold raises transmit-empty; two characters must be loaded before it rises again.
// R16: Transmit DMA request asserts when spaces exceed threshold, drops when full.
// R17: Pending transmit interrupt holds until a holding write or identification read.
// R18: Cleared by identification read without writes, draining empty raises nothing.
// R19: Any write services the flag; draining empty before refill raises it again.
// R20: Resetting the transmit FIFO raises the transmit-empty interrupt.
// R21: Without 0xBF in line-control, shared offsets reach the normal register set.
package uec_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [2:0] OFS_HOLD      = 3'h0;
  localparam logic [2:0] OFS_IRQ_EN    = 3'h1;
  localparam logic [2:0] OFS_FIFO_CTL  = 3'h2;
  localparam logic [2:0] OFS_LINE_CTL  = 3'h3;
  localparam logic [2:0] OFS_MODEM_CTL = 3'h4;
  localparam logic [2:0] OFS_LINE_STAT = 3'h5;
  localparam logic [2:0] OFS_RESUME1   = 3'h4;
  localparam logic [2:0] OFS_RESUME2   = 3'h5;
  localparam logic [2:0] OFS_PAUSE1    = 3'h6;
  localparam logic [2:0] OFS_PAUSE2    = 3'h7;

  localparam logic [7:0] BANK_KEY = 8'hbf;
  localparam logic [7:0] REG_RST  = 8'h00;

  // ==========================================================
  // Field positions
  localparam int FE_GATE     = 4;
  localparam int FE_AUTO_RTS = 6;
  localparam int FE_AUTO_CTS = 7;
  localparam int MC_RTS      = 1;
  localparam int MC_IR       = 6;
  localparam int MC_PRESC    = 7;
  localparam int FC_ENABLE   = 0;
  localparam int FC_TX_RST   = 2;
  localparam int FC_DMA_MODE = 3;
  localparam int FC_TXLVL_LO = 4;
  localparam int IE_THRE     = 1;
  localparam int IE_RTS      = 6;
  localparam int IE_CTS      = 7;
  localparam int LC_DLAB     = 7;
  localparam int LS_FIFO_EMP = 5;
  localparam int LS_ALL_EMP  = 6;

  // Fields writable only while the bank gate is set, and the fifo-control pulse bits (FC_PULSES)
  localparam logic [7:0] IE_GATED   = 8'hf0;
  localparam logic [7:0] MC_GATED   = 8'he0;
  localparam logic [7:0] FC_GATED   = 8'h30;
  localparam logic [7:0] FC_PULSES  = 8'h06;

  // ==========================================================
  // Interrupt identification codes
  localparam logic [4:0] CODE_NONE = 5'h00;
  localparam logic [4:0] CODE_THRE = 5'h01;
  localparam logic [4:0] CODE_FLOW = 5'h10;

  // ==========================================================
  // Sizes and counts
  localparam int         DEPTH_SMALL  = 16;
  localparam int         DEPTH_LARGE  = 64;
  localparam logic [1:0] HYST_CHARS   = 2'h2;
  localparam logic [1:0] PRESC_LAST   = 2'h3;

  function automatic logic [6:0] tx_space_level(input logic [1:0] sel);
    case (sel)
      2'h0:    return 7'h08;
      2'h1:    return 7'h10;
      2'h2:    return 7'h20;
      default: return 7'h38;
    endcase
  endfunction : tx_space_level

  function automatic logic [7:0] gated_merge(input logic [7:0] old, input logic [7:0] din,
                                             input logic [7:0] mask, input logic open);
    return open ? din : ((din & ~mask) | (old & mask));
  endfunction : gated_merge

endpackage : uec_pkg

// >>> rtl/uec_tx_fifo.sv
module uec_tx_fifo
  import uec_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = DEPTH_LARGE
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   flush,
  input  wire logic                   push,
  input  wire logic [WIDTH-1:0]       pushData,
  input  wire logic                   pop,
  output logic      [WIDTH-1:0]       headData,
  output logic      [$clog2(DEPTH):0] count
);

  localparam int AW = $clog2(DEPTH);

  generate
    if ((1 << AW) != DEPTH) begin : g_bad_depth
      $error("uec_tx_fifo depth must be a power of two");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    wrPtr_nxt;
  logic [AW-1:0]    rdPtr_r;
  logic [AW-1:0]    rdPtr_nxt;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;

  // ==========================================================
  // Pointers
  always_comb begin
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (flush) begin
      wrPtr_nxt = '0;
      rdPtr_nxt = '0;
      count_nxt = '0;
    end else begin
      if (push) wrPtr_nxt = wrPtr_r + 1'b1;
      if (pop) rdPtr_nxt = rdPtr_r + 1'b1;
      count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end

  // Storage carries no reset; the count decides what is valid
  always_ff @(posedge clk) begin
    if (push && !flush) mem[wrPtr_r] <= pushData;
  end

  assign headData = mem[rdPtr_r];
  assign count    = count_r;

endmodule : uec_tx_fifo
